/* logic/pbsp_device.sv */
// pbsp_device: slave end of the processor bus port, bridging to an internal system bus
// assumes clk is the system clock; every pin is synchronised here
// Notes on behaviour
// - selected only when both chip selects active
// - master holds selects through whole data phase
// - early selects save one cycle on reads
// - pins sampled and driven on bus clock rise, interrupt pin excepted
// - asynchronous mode, every pin crosses through two flops toward system bus
// - size 01 byte, 10 half, 00 word
// - direction high read, low write, held throughout
// - burst flag low burst, high single beat
// - pending-beat low requests next burst beat
// - pending-beat released early aborts the burst
// - port width 8 or 16, low lane D7-0
// - master drives data on write, device on read
// - one parity bit per byte lane
// - interrupt low on bus or configuration error
module pbsp_device (
  // clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // port pins
  pbsp_if.dev bus,
  // configuration
  input wire logic wide16,
  input wire logic irqClear,
  // system bus master side
  output logic sysReq,
  output logic sysWrite,
  output logic [pbsp_pkg::ADDR_W-1:0] sysAddr,
  output logic [pbsp_pkg::DATA_W-1:0] sysWdata,
  output logic [pbsp_pkg::PAR_W-1:0] sysBe,
  input wire logic [pbsp_pkg::DATA_W-1:0] sysRdata,
  input wire logic sysAck,
  input wire logic sysErr
);
  import pbsp_pkg::*;

  localparam int IN_W = 9 + ADDR_W + DATA_W + PAR_W;

  logic [IN_W-1:0] pinRaw;
  logic [IN_W-1:0] pinMeta_reg;
  logic [IN_W-1:0] pinSync_reg;
  logic sClk, sSelLowN, sSelHigh, sTsN, sRnw, sBurstN, sBdipN;
  logic [1:0] sSize;
  logic [ADDR_W-1:0] sAddr;
  logic [DATA_W-1:0] sData;
  logic [PAR_W-1:0] sPar;
  logic clkPrev_reg;
  logic riseEv;
  pbsp_dev_state_t state_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [1:0] size_reg;
  logic rnw_reg;
  logic burst_reg;
  logic [2:0] beat_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic csOk, inIdle, contBurst, startBeat, parBad, beatErr, errEv;
  logic [1:0] curSize;
  logic curRnw;
  logic [ADDR_W-1:0] beatAddr;
  logic [PAR_W-1:0] beatBe;
  logic [DATA_W-1:0] laneData;
  logic sysReq_reg, sysWrite_reg;
  logic [ADDR_W-1:0] sysAddr_reg;
  logic [DATA_W-1:0] sysWdata_reg;
  logic [PAR_W-1:0] sysBe_reg;
  logic [DATA_W-1:0] devData_reg;
  logic [PAR_W-1:0] devParity_reg;
  logic devDataOe_reg, ackN_reg, irqN_reg;

  // gather every incoming pin into one word for the synchroniser
  assign pinRaw = {bus.processorBusClock, bus.selectLowIn, bus.selectHighIn,
                   bus.transferStartN, bus.readNotWrite, bus.burstFlagN,
                   bus.burstBeatPendingN, bus.transferSize, bus.portAddr,
                   bus.portData, bus.portParity};

  // two flops on every pin before any logic reads it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end else if (ce) begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign {sClk, sSelLowN, sSelHigh, sTsN, sRnw, sBurstN, sBdipN, sSize, sAddr,
          sData, sPar} = pinSync_reg;

  // rising edge of the bus clock paces all pin sampling and all driving except the interrupt pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clkPrev_reg <= 1'b0;
    end else if (ce) begin
      clkPrev_reg <= sClk;
    end
  end

  assign riseEv = sClk & ~clkPrev_reg;

  // beat decode: selection, size, lanes, parity and continuation
  assign csOk = ~sSelLowN & sSelHigh;
  assign inIdle = (state_reg == D_IDLE);
  assign curSize = inIdle ? sSize : size_reg;
  assign curRnw = inIdle ? sRnw : rnw_reg;
  assign beatBe = laneMask(curSize);
  assign beatAddr = (state_reg == D_DECIDE) ? addr_reg + sizeStep(size_reg) :
                    (inIdle ? sAddr : addr_reg);
  assign parBad = ~curRnw & (|((laneParity(sData) ^ sPar) & beatBe));
  assign beatErr = ~sizeFits(curSize, wide16) | parBad;
  assign contBurst = burst_reg && (beat_reg != BURST_BEATS) && csOk && ~sBdipN;
  assign startBeat = riseEv && ((inIdle && ~sTsN && csOk && sRnw) ||
                                ((state_reg == D_WAITCS) && csOk) ||
                                ((state_reg == D_DECIDE) && contBurst));
  assign laneData = wide16 ? sData : {{BYTE_W{1'b0}}, sData[BYTE_W-1:0]};

  // transfer sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= D_IDLE;
    end else if (ce) begin
      if (startBeat) begin
        state_reg <= beatErr ? D_PRESENT : D_REQ;
      end else begin
        case (state_reg)
          D_IDLE: begin
            if (riseEv && !sTsN) begin
              state_reg <= D_WAITCS;
            end
          end
          D_WAITCS, D_DECIDE: begin
            if (riseEv) begin
              state_reg <= D_IDLE;
            end
          end
          D_REQ: begin
            if (sysAck) begin
              state_reg <= D_PRESENT;
            end
          end
          D_PRESENT: begin
            if (riseEv) begin
              state_reg <= D_HOLD;
            end
          end
          D_HOLD: begin
            if (riseEv) begin
              state_reg <= D_DECIDE;
            end
          end
          default: begin
            state_reg <= D_IDLE;
          end
        endcase
      end
    end
  end

  // transfer attributes caught in the address phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      size_reg <= TSIZE_WORD;
      rnw_reg <= 1'b1;
      burst_reg <= 1'b0;
      addr_reg <= '0;
      beat_reg <= '0;
    end else if (ce) begin
      if (riseEv && inIdle && !sTsN) begin
        size_reg <= sSize;
        rnw_reg <= sRnw;
        burst_reg <= ~sBurstN;
        beat_reg <= '0;
      end else if (riseEv && (state_reg == D_HOLD)) begin
        beat_reg <= beat_reg + BEAT_ONE;
      end
      if (startBeat) begin
        addr_reg <= beatAddr;
      end else if (riseEv && inIdle && !sTsN) begin
        addr_reg <= sAddr;
      end
    end
  end

  // system bus request, held until acknowledged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sysReq_reg <= 1'b0;
      sysWrite_reg <= 1'b0;
      sysAddr_reg <= '0;
      sysWdata_reg <= '0;
      sysBe_reg <= '0;
    end else if (ce) begin
      if (startBeat) begin
        sysReq_reg <= ~beatErr;
        sysWrite_reg <= ~curRnw;
        sysAddr_reg <= beatAddr;
        sysWdata_reg <= curRnw ? '0 : laneData;
        sysBe_reg <= beatBe;
      end else if (sysAck) begin
        sysReq_reg <= 1'b0;
      end
    end
  end

  // read data returned by the system bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else if (ce) begin
      if (startBeat) begin
        rdata_reg <= '0;
      end else if ((state_reg == D_REQ) && sysAck) begin
        rdata_reg <= wide16 ? sysRdata : {{BYTE_W{1'b0}}, sysRdata[BYTE_W-1:0]};
      end
    end
  end

  // acknowledge and read data driven for one bus clock period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ackN_reg <= 1'b1;
      devDataOe_reg <= 1'b0;
      devData_reg <= '0;
      devParity_reg <= '0;
    end else if (ce && riseEv) begin
      if (state_reg == D_PRESENT) begin
        ackN_reg <= 1'b0;
        devDataOe_reg <= rnw_reg;
        devData_reg <= rdata_reg;
        devParity_reg <= laneParity(rdata_reg) & laneMask(size_reg);
      end else if (state_reg == D_HOLD) begin
        ackN_reg <= 1'b1;
        devDataOe_reg <= 1'b0;
        devData_reg <= '0;
        devParity_reg <= '0;
      end
    end
  end

  // interrupt: low from an error until cleared; a new error wins
  assign errEv = (startBeat && beatErr) || ((state_reg == D_REQ) && sysAck && sysErr);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqN_reg <= 1'b1;
    end else if (ce) begin
      if (errEv) begin
        irqN_reg <= 1'b0;
      end else if (irqClear) begin
        irqN_reg <= 1'b1;
      end
    end
  end

  // outputs straight from flops
  assign sysReq = sysReq_reg;
  assign sysWrite = sysWrite_reg;
  assign sysAddr = sysAddr_reg;
  assign sysWdata = sysWdata_reg;
  assign sysBe = sysBe_reg;
  assign bus.devData = devData_reg;
  assign bus.devParity = devParity_reg;
  assign bus.devDataOe = devDataOe_reg;
  assign bus.transferAckN = ackN_reg;
  assign bus.portIrqN = irqN_reg;

endmodule // pbsp_device

/* logic/pbsp_host.sv */
// pbsp_host: processor (bus master) end of the processor bus port
// assumes clk is the host clock; the bus clock is divided from it and driven out
module pbsp_host (
  // clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // port pins
  pbsp_if.host bus,
  // command side
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic cmdBurst,
  input wire logic cmdEarlySel,
  input wire logic [1:0] cmdSize,
  input wire logic [pbsp_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic [pbsp_pkg::DATA_W-1:0] cmdWdata,
  input wire logic abortReq,
  // beat results
  output logic beatDone,
  output logic [pbsp_pkg::DATA_W-1:0] beatRdata,
  output logic beatParOk,
  output logic irqSeen
);
  import pbsp_pkg::*;

  localparam int IN_W = 2 + DATA_W + PAR_W;

  logic [IN_W-1:0] inMeta_reg;
  logic [IN_W-1:0] inSync_reg;
  logic sAckN, sIrqN;
  logic [DATA_W-1:0] sData;
  logic [PAR_W-1:0] sPar;
  logic [DIV_W-1:0] div_reg;
  logic linkClk_reg;
  logic toggle, riseNow, fallNow;
  pbsp_host_state_t state_reg;
  logic write_reg, burst_reg;
  logic [1:0] size_reg;
  logic [2:0] beat_reg;
  logic selOn_reg, tsN_reg, rnw_reg, burstN_reg, bdipN_reg, oe_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic [PAR_W-1:0] par_reg;
  logic ready_reg, done_reg, parOk_reg, irq_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic moreBeats;

  // device replies pass two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inMeta_reg <= '1;
      inSync_reg <= '1;
    end else if (ce) begin
      inMeta_reg <= {bus.transferAckN, bus.portIrqN, bus.portData, bus.portParity};
      inSync_reg <= inMeta_reg;
    end
  end

  assign {sAckN, sIrqN, sData, sPar} = inSync_reg;

  // bus clock divider
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
      linkClk_reg <= 1'b0;
    end else if (ce) begin
      if (toggle) begin
        div_reg <= '0;
        linkClk_reg <= ~linkClk_reg;
      end else begin
        div_reg <= div_reg + DIV_ONE;
      end
    end
  end

  assign toggle = (div_reg == LINK_HALF_CYC - DIV_ONE);
  assign riseNow = toggle & ~linkClk_reg;
  assign fallNow = toggle & linkClk_reg;
  assign moreBeats = burst_reg && (beat_reg != BURST_BEATS) && !abortReq;

  // master sequencing: pins change on the fall, replies are read on the rise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= H_IDLE;
      ready_reg <= 1'b1;
      write_reg <= 1'b0;
      burst_reg <= 1'b0;
      size_reg <= TSIZE_BYTE;
      beat_reg <= '0;
      selOn_reg <= 1'b0;
      tsN_reg <= 1'b1;
      rnw_reg <= 1'b1;
      burstN_reg <= 1'b1;
      bdipN_reg <= 1'b1;
      oe_reg <= 1'b0;
      addr_reg <= '0;
      data_reg <= '0;
      par_reg <= '0;
    end else if (ce) begin
      case (state_reg)
        H_IDLE: begin
          if (fallNow && cmdValid) begin
            state_reg <= H_ADDR;
            ready_reg <= 1'b0;
            write_reg <= cmdWrite;
            burst_reg <= cmdBurst;
            size_reg <= cmdSize;
            beat_reg <= '0;
            tsN_reg <= 1'b0;
            selOn_reg <= cmdEarlySel;
            rnw_reg <= ~cmdWrite;
            burstN_reg <= ~cmdBurst;
            addr_reg <= cmdAddr;
          end
        end
        H_ADDR: begin
          if (fallNow) begin
            state_reg <= H_DATA;
            tsN_reg <= 1'b1;
            selOn_reg <= 1'b1;
            bdipN_reg <= ~burst_reg;
            oe_reg <= write_reg;
            data_reg <= cmdWdata;
            par_reg <= laneParity(cmdWdata);
          end
        end
        H_DATA: begin
          if (riseNow && !sAckN) begin
            state_reg <= H_NEXT;
            beat_reg <= beat_reg + BEAT_ONE;
          end
        end
        H_NEXT: begin
          if (fallNow) begin
            if (moreBeats) begin
              state_reg <= H_DATA;
              data_reg <= cmdWdata;
              par_reg <= laneParity(cmdWdata);
            end else begin
              state_reg <= H_IDLE;
              ready_reg <= 1'b1;
              selOn_reg <= 1'b0;
              bdipN_reg <= 1'b1;
              burstN_reg <= 1'b1;
              oe_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // beat result captured at the acknowledging rise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
      rdata_reg <= '0;
      parOk_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= (state_reg == H_DATA) && riseNow && !sAckN;
      if ((state_reg == H_DATA) && riseNow && !sAckN && !write_reg) begin
        rdata_reg <= sData;
        parOk_reg <= ~(|((laneParity(sData) ^ sPar) & laneMask(size_reg)));
      end
      irq_reg <= ~sIrqN;
    end
  end

  // outputs straight from flops, selectLowIn inverted from selOn_reg
  assign cmdReady = ready_reg;
  assign beatDone = done_reg;
  assign beatRdata = rdata_reg;
  assign beatParOk = parOk_reg;
  assign irqSeen = irq_reg;
  assign bus.processorBusClock = linkClk_reg;
  assign bus.selectLowIn = ~selOn_reg;
  assign bus.selectHighIn = selOn_reg;
  assign bus.transferStartN = tsN_reg;
  assign bus.portAddr = addr_reg;
  assign bus.transferSize = size_reg;
  assign bus.readNotWrite = rnw_reg;
  assign bus.burstFlagN = burstN_reg;
  assign bus.burstBeatPendingN = bdipN_reg;
  assign bus.hostData = data_reg;
  assign bus.hostParity = par_reg;
  assign bus.hostDataOe = oe_reg;

endmodule // pbsp_host

/* logic/pbsp_if.sv */
// pbsp_if: pins between processor (host) and slave port (device)
// assumes the testbench joins both ends through it
interface pbsp_if;
  import pbsp_pkg::*;

  // bus clock and transfer attributes from the host
  logic processorBusClock;
  logic selectLowIn;
  logic selectHighIn;
  logic transferStartN;
  logic [ADDR_W-1:0] portAddr;
  logic [1:0] transferSize;
  logic readNotWrite;
  logic burstFlagN;
  logic burstBeatPendingN;
  // shared data and parity, one driver set per end
  logic [DATA_W-1:0] hostData;
  logic [PAR_W-1:0] hostParity;
  logic hostDataOe;
  logic [DATA_W-1:0] devData;
  logic [PAR_W-1:0] devParity;
  logic devDataOe;
  logic [DATA_W-1:0] portData;
  logic [PAR_W-1:0] portParity;
  // device replies
  logic transferAckN;
  logic portIrqN;

  // resolved level of the shared pins, pulled high when nobody drives
  assign portData = devDataOe ? devData : (hostDataOe ? hostData : '1);
  assign portParity = devDataOe ? devParity : (hostDataOe ? hostParity : '1);

  modport dev (
    input processorBusClock, selectLowIn, selectHighIn, transferStartN, portAddr,
    input transferSize, readNotWrite, burstFlagN, burstBeatPendingN, portData, portParity,
    output devData, devParity, devDataOe, transferAckN, portIrqN
  );

  modport host (
    output processorBusClock, selectLowIn, selectHighIn, transferStartN, portAddr,
    output transferSize, readNotWrite, burstFlagN, burstBeatPendingN,
    output hostData, hostParity, hostDataOe,
    input portData, portParity, transferAckN, portIrqN
  );

endinterface

/* logic/pbsp_pkg.sv */
// pbsp_pkg: widths, encodings, timing and helpers of the port
// assumes both port ends and their system clock run at 250 MHz
package pbsp_pkg;

  // widths of the port
  localparam int DATA_W = 16;
  localparam int PAR_W = 2;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;

  // transfer size encodings driven by the master
  localparam logic [1:0] TSIZE_BYTE = 2'h1;
  localparam logic [1:0] TSIZE_HALF = 2'h2;
  localparam logic [1:0] TSIZE_WORD = 2'h0;

  // byte lane masks and address steps per size
  localparam logic [PAR_W-1:0] LANES_BYTE = 2'h1;
  localparam logic [PAR_W-1:0] LANES_HALF = 2'h3;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_HALF = 16'h0002;

  // beats in a burst
  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam logic [2:0] BEAT_ONE = 3'h1;

  // timing of the bus clock that the host derives from its own clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_PERIOD_NS = 64;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] LINK_HALF_CYC = DIV_W'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;

  // device end states
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_WAITCS = 3'h1,
    D_REQ = 3'h2,
    D_PRESENT = 3'h3,
    D_HOLD = 3'h4,
    D_DECIDE = 3'h5
  } pbsp_dev_state_t;

  // host end states
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_ADDR = 2'h1,
    H_DATA = 2'h2,
    H_NEXT = 2'h3
  } pbsp_host_state_t;

  // even parity, one bit per byte lane
  function automatic logic [PAR_W-1:0] laneParity(input logic [DATA_W-1:0] d);
    return {^d[2*BYTE_W-1:BYTE_W], ^d[BYTE_W-1:0]};
  endfunction

  // whether a transfer size fits the configured port width
  function automatic logic sizeFits(input logic [1:0] s, input logic wide);
    return (s == TSIZE_BYTE) || ((s == TSIZE_HALF) && wide);
  endfunction

  // lanes carried by a transfer size
  function automatic logic [PAR_W-1:0] laneMask(input logic [1:0] s);
    return (s == TSIZE_HALF) ? LANES_HALF : LANES_BYTE;
  endfunction

  // address advance per beat
  function automatic logic [ADDR_W-1:0] sizeStep(input logic [1:0] s);
    return (s == TSIZE_HALF) ? STEP_HALF : STEP_BYTE;
  endfunction

endpackage

/* tb/pbsp_monitor.sv */
// pbsp_monitor: pin checks between the two port ends
// assumes clk and resetn drive both ends and every pin is sampled on clk
module pbsp_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // port pins
  input wire logic processorBusClock,
  input wire logic selectLowIn,
  input wire logic selectHighIn,
  input wire logic [1:0] transferSize,
  input wire logic readNotWrite,
  input wire logic [pbsp_pkg::DATA_W-1:0] devData,
  input wire logic [pbsp_pkg::PAR_W-1:0] devParity,
  input wire logic devDataOe,
  input wire logic transferAckN,
  input wire logic portIrqN
);
  timeunit 1ns;
  timeprecision 100ps;
  import pbsp_pkg::*;
  logic [7:0] ackLenReg;
  logic selOn;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // both selects active
  assign selOn = !selectLowIn && selectHighIn;

  // cycles the acknowledge has been low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      ackLenReg <= 8'h00;
    else
      ackLenReg <= transferAckN ? 8'h00 : ackLenReg + 8'h01;
  end

  sequence busHigh8;
    processorBusClock [*8];
  endsequence
  sequence ackStart;
    $fell(transferAckN);
  endsequence

  clk_high_a: assert property ($rose(processorBusClock) |-> busHigh8 ##1 !processorBusClock)
    else $error("bus clock high not 8 cycles");
  ack_edge_a: assert property (ackStart |-> processorBusClock && !$past(processorBusClock, 6))
    else $error("ack not on bus clock rise");
  ack_len_a: assert property ($rose(transferAckN) |-> ackLenReg[3:0] == 4'h0 && ackLenReg != 8'h00)
    else $error("ack length not whole clocks");
  ack_sel_a: assert property (ackStart |-> selOn)
    else $error("ack without selects");
  oe_read_a: assert property (devDataOe |-> readNotWrite && !transferAckN)
    else $error("data driven outside read beat");
  rd_drive_a: assert property (ackStart ##0 readNotWrite |-> devDataOe)
    else $error("read ack without data");
  par_low_a: assert property (devDataOe |-> devParity[0] == ^devData[7:0])
    else $error("low lane parity wrong");
  par_high_a: assert property (devDataOe && transferSize == TSIZE_HALF |-> devParity[1] == ^devData[15:8])
    else $error("high lane parity wrong");
  irq_size_a: assert property ($fell(transferAckN) && transferSize == TSIZE_WORD |-> ##[0:8] !portIrqN)
    else $error("word size raised no irq");
endmodule // pbsp_monitor

/* tb/processor_bus_slave_port_tb.sv */
// processor_bus_slave_port_tb: both ends joined, system side answered here
// assumes a second device end, hand driven, for select faults
module processor_bus_slave_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pbsp_pkg::*;
  logic clk, resetn, wide16, irqClear, cmdValid, cmdReady, cmdWrite, cmdBurst, cmdEarlySel;
  logic abortReq, beatDone, beatParOk, irqSeen, sysReq, sysWrite, sysAck, sysErr, sysReq2;
  logic errInject, quiet;
  logic [1:0] cmdSize;
  logic [PAR_W-1:0] sysBe;
  logic [ADDR_W-1:0] cmdAddr, sysAddr;
  logic [DATA_W-1:0] cmdWdata, beatRdata, sysWdata, sysRdata;
  logic [31:0] seed = 32'h29FF;
  logic [50:0] sysQ[$];
  logic [31:0] rdQ[$];
  logic [1:0] beatQ[$];
  int err_total, n_tests, ackDelay, dly, lat0, lat1;
  pbsp_if bus ();
  pbsp_if bus2 ();

  pbsp_host pbsp_host_inst (.clk(clk), .resetn(resetn), .ce(1'b1), .bus(bus.host),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdBurst(cmdBurst),
    .cmdEarlySel(cmdEarlySel), .cmdSize(cmdSize), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .abortReq(abortReq), .beatDone(beatDone), .beatRdata(beatRdata), .beatParOk(beatParOk),
    .irqSeen(irqSeen));
  pbsp_device pbsp_device_inst (.clk(clk), .resetn(resetn), .ce(1'b1), .bus(bus.dev),
    .wide16(wide16), .irqClear(irqClear), .sysReq(sysReq), .sysWrite(sysWrite),
    .sysAddr(sysAddr), .sysWdata(sysWdata), .sysBe(sysBe), .sysRdata(sysRdata),
    .sysAck(sysAck), .sysErr(sysErr));
  pbsp_device pbsp_device_inst2 (.clk(clk), .resetn(resetn), .ce(1'b1), .bus(bus2.dev),
    .wide16(wide16), .irqClear(irqClear), .sysReq(sysReq2), .sysWrite(), .sysAddr(),
    .sysWdata(), .sysBe(), .sysRdata(sysRdata), .sysAck(sysReq2), .sysErr(sysErr));
  pbsp_monitor pbsp_monitor_inst (.clk(clk), .resetn(resetn),
    .processorBusClock(bus.processorBusClock), .selectLowIn(bus.selectLowIn),
    .selectHighIn(bus.selectHighIn), .transferSize(bus.transferSize),
    .readNotWrite(bus.readNotWrite), .devData(bus.devData), .devParity(bus.devParity),
    .devDataOe(bus.devDataOe), .transferAckN(bus.transferAckN), .portIrqN(bus.portIrqN));

  // system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // a wait that ran out ends the run
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // issue one command, noting each beat unless quiet
  task automatic runCmd(input logic wr, input logic bu, input logic es, input logic [1:0] sz);
    int k;
    logic bad;
    logic [31:0] r;
    logic [15:0] m, d, a, a0;
    r = rnd();
    bad = (sz == TSIZE_WORD) || (sz == TSIZE_HALF && !wide16);
    m = !wr ? 16'h0000 : (!wide16 || sz == TSIZE_HALF) ? 16'hFFFF : 16'h00FF;
    d = wide16 ? r[15:0] : {8'h00, r[7:0]};
    a0 = (sz == TSIZE_HALF) ? {r[31:17], 1'b0} : r[31:16];
    a = a0;
    for (k = 0; k < (bu ? 4 : 1) && !quiet; k++) begin
      beatQ.push_back({!wr, bad});
      if (!bad) sysQ.push_back({m, wr, a, (sz == TSIZE_HALF) ? 2'h3 : 2'h1, d & m});
      a = a + ((sz == TSIZE_HALF) ? 16'h0002 : 16'h0001);
    end
    for (k = 0; k < 2000 && cmdReady !== 1'b1; k++) @(posedge clk);
    guard(k, 2000);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdBurst <= bu;
    cmdEarlySel <= es;
    cmdSize <= sz;
    cmdAddr <= a0;
    cmdWdata <= r[15:0];
    for (k = 0; k < 200 && cmdReady !== 1'b0; k++) @(posedge clk);
    guard(k, 200);
    cmdValid <= 1'b0;
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 3000 && (beatQ.size() != 0 || cmdReady !== 1'b1); k++) @(posedge clk);
    guard(k, 3000);
    tick(20);
  endtask

  task automatic clearIrq();
    irqClear <= 1'b1;
    tick(1);
    irqClear <= 1'b0;
    tick(12);
    check(irqSeen, 1'b0);
  endtask

  task automatic readLat(input logic es, output int lat);
    runCmd(1'b0, 1'b0, es, TSIZE_BYTE);
    for (lat = 0; lat < 300 && beatDone !== 1'b1; lat++) @(posedge clk);
    guard(lat, 300);
    drain();
  endtask

  // wrong select levels on the spare port draw no answer
  task automatic badSelect(input logic lowIn, input logic highIn);
    int k, hits;
    hits = 0;
    bus2.selectLowIn <= lowIn;
    bus2.selectHighIn <= highIn;
    bus2.transferStartN <= 1'b0;
    for (k = 0; k < 10; k++) begin
      #32 bus2.processorBusClock <= ~bus2.processorBusClock;
      if (k == 1)
        bus2.transferStartN <= 1'b1;
      hits += (bus2.transferAckN !== 1'b1) + (sysReq2 !== 1'b0) + (bus2.devDataOe !== 1'b0);
    end
    check(hits, 0);
    bus2.selectLowIn <= 1'b1;
    bus2.selectHighIn <= 1'b0;
  endtask

  // system side answers each request and checks it unless quiet
  always @(posedge clk) begin
    logic [50:0] e;
    logic [31:0] r;
    sysAck <= 1'b0;
    if (resetn && sysReq === 1'b1 && sysAck === 1'b0) begin
      if (dly < ackDelay)
        dly++;
      else begin
        dly = 0;
        e = quiet ? '0 : sysQ.pop_front();
        r = rnd();
        if (!quiet) check({sysWrite, sysAddr, sysBe, sysWdata & e[50:35]}, e[34:0]);
        if (!quiet && !sysWrite) rdQ.push_back({e[17] ? 16'hFFFF : 16'h00FF, r[15:0]});
        sysRdata <= r[15:0];
        sysErr <= errInject;
        sysAck <= 1'b1;
      end
    end
  end

  // beat results and pin levels
  always @(posedge clk) begin
    logic [1:0] b;
    logic [31:0] x;
    if (resetn && bus.devDataOe === 1'b1)
      check({bus.portParity[0], bus.readNotWrite}, {^bus.portData[7:0], 1'b1});
    if (resetn && !quiet && beatDone === 1'b1) begin
      b = beatQ.pop_front();
      x = b[0] ? 32'h00FF0000 : rdQ.pop_front();
      if (b[1]) check({beatRdata & x[31:16], beatParOk}, {x[15:0] & x[31:16], 1'b1});
    end
  end

  initial begin
    resetn = 1'b0;
    {wide16, quiet} = 2'h2;
    {irqClear, cmdValid, cmdWrite, cmdBurst, cmdEarlySel, abortReq, errInject} = 7'h00;
    {cmdSize, cmdAddr, cmdWdata, sysRdata, sysAck, sysErr} = '0;
    {bus2.processorBusClock, bus2.selectHighIn, bus2.portAddr, bus2.hostData} = '0;
    {bus2.selectLowIn, bus2.transferStartN, bus2.readNotWrite} = 3'h7;
    {bus2.burstFlagN, bus2.burstBeatPendingN, bus2.hostDataOe, bus2.hostParity} = 5'h18;
    bus2.transferSize = TSIZE_BYTE;
    {ackDelay, dly} = 0;
    tick(4);
    resetn <= 1'b1;
    // every size, direction, select timing and burst, 16-bit port
    for (int i = 0; i < 16; i++) begin
      ackDelay = rnd() % 4;
      runCmd(i[0], i[2], i[1], i[3] ? TSIZE_HALF : TSIZE_BYTE);
      drain();
    end
    runCmd(1'b0, 1'b0, 1'b1, TSIZE_WORD);
    drain();
    check(irqSeen, 1'b1);
    clearIrq();
    errInject = 1'b1;
    runCmd(1'b0, 1'b0, 1'b0, TSIZE_BYTE);
    drain();
    errInject = 1'b0;
    check(irqSeen, 1'b1);
    clearIrq();
    // 8-bit port: half refused, bytes on low lane
    wide16 <= 1'b0;
    tick(2);
    runCmd(1'b0, 1'b0, 1'b0, TSIZE_HALF);
    runCmd(1'b1, 1'b1, 1'b0, TSIZE_BYTE);
    runCmd(1'b0, 1'b1, 1'b1, TSIZE_BYTE);
    drain();
    check(irqSeen, 1'b1);
    clearIrq();
    wide16 <= 1'b1;
    // early selects save one bus clock on a read
    ackDelay = 0;
    readLat(1'b1, lat0);
    readLat(1'b0, lat1);
    check(lat1 - lat0, 16);
    // burst aborted after one beat
    quiet = 1'b1;
    runCmd(1'b0, 1'b1, 1'b1, TSIZE_BYTE);
    lat0 = 0;
    for (lat1 = 0; lat1 < 600 && !(lat0 > 0 && cmdReady === 1'b1); lat1++) begin
      @(posedge clk);
      if (beatDone === 1'b1) begin
        lat0++;
        abortReq <= 1'b1;
      end
    end
    guard(lat1, 600);
    abortReq <= 1'b0;
    tick(64);
    check(lat0 > 0 && lat0 < 4, 1'b1);
    badSelect(1'b1, 1'b1);
    badSelect(1'b0, 1'b0);
    close_out();
  end
endmodule // processor_bus_slave_port_tb
